// >>> dv/meas_front_end.sv
// Measurement front end and blocking matrix source feeding the protection core
module meas_front_end (
  input wire logic clock,
  input wire logic [prot_pkg::MAG_W-1:0] req_mag,
  input wire logic req_block,
  output logic [prot_pkg::MAG_W-1:0] magnitude,
  output logic block_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Values move just after an edge and hold well past the next sample point
  always_ff @(posedge clock) begin
    magnitude <= req_mag;
    block_in <= req_block;
  end
endmodule

// >>> dv/protection_pickup_block_timer_test.sv
// Self-checking bench for the protection pick-up, blocking and trip core
module protection_pickup_block_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CC = 8;
  logic clock = 0;
  logic rst_n = 0;
  logic test_mode = 0;
  logic sw_block = 0;
  logic req_block = 0;
  logic [15:0] req_mag = 16'h0000;
  logic [15:0] magnitude;
  logic block_in, pickup, start, blocked, trip, cycle_tick;
  prot_pkg::settings_t cfg = prot_pkg::SETTINGS_DEFAULT;
  prot_pkg::block_report_t report;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int pk, st, bl, tr, ev, el, sv, lvl, m;
  int ticks = 0;
  longint acc, w, ex;

  always #25 clock = ~clock;

  meas_front_end PART (.clock(clock), .req_mag(req_mag), .req_block(req_block),
    .magnitude(magnitude), .block_in(block_in));

  protection_pickup_block_timer #(.CYCLE_CLKS(CC)) DUT (.clock(clock), .rst_n(rst_n),
    .magnitude(magnitude), .settings(cfg), .block_in(block_in), .test_mode(test_mode),
    .sw_block(sw_block), .pickup(pickup), .start(start), .blocked(blocked), .trip(trip),
    .cycle_tick(cycle_tick), .report(report));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Reference behaviour of one processing cycle
  task automatic model(int b);
    lvl = cfg.pickup_level;
    if (cfg.under_mode) pk = pk ? (m * 97 <= lvl * 100) : (m < lvl);
    else pk = pk ? (m * 100 >= lvl * 97) : (m > lvl);
    ev = 0;
    ex = cfg.under_mode ? lvl - m : m - lvl;
    if (ex < 0) ex = 0;
    w = cfg.curve_series ? ex + ((ex * ex) >> 16) : ex;
    if (!pk) begin
      st = 0;
      bl = 0;
      tr = 0;
    end else if (bl) begin
      bl = 1;
    end else if (b) begin
      if (!st) sv = m;
      bl = 1;
      st = 0;
      tr = 0;
      ev = 1;
    end else if (!st) begin
      sv = m;
      el = 0;
      acc = 0;
      st = 1;
      tr = (cfg.delay_type == prot_pkg::definite_time_mode && cfg.min_delay == 0);
    end else begin
      el++;
      if (cfg.delay_type == prot_pkg::definite_time_mode) begin
        if (el >= cfg.min_delay) tr = 1;
      end else begin
        if (acc + w >= cfg.time_dial * lvl && el >= cfg.min_delay) tr = 1;
        acc += w;
      end
    end
  endtask

  task automatic step(int mag, bit b, bit s = 0, bit t = 0);
    req_mag = 16'(mag);
    req_block = b;
    sw_block = s;
    test_mode = t;
    m = mag;
    @(posedge clock);
    #2;
    while (cycle_tick !== 1'b1) begin
      @(posedge clock);
      #2;
    end
    ticks++;
    model(b | (s & t));
    repeat (2) @(posedge clock);
    #2;
    check("pickup", pk, pickup);
    check("start", st, start);
    check("blocked", bl, blocked);
    check("trip", tr, trip);
    check("display_event", ev, report.display_event);
    check("block_event", ev, report.block_event);
    if (ev) begin
      check("start_value", sv, report.start_value);
      check("fault_under", cfg.under_mode, report.fault_under);
      check("stamp", ticks, report.stamp);
    end
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    pk = 0;
    st = 0;
    bl = 0;
    tr = 0;
    lvl = $urandom(32'hb832);
    repeat (3) @(posedge clock);
    #2;
    rst_n = 1;
    check("min_default", 8, prot_pkg::SETTINGS_DEFAULT.min_delay);
    check("type_default", 0, prot_pkg::SETTINGS_DEFAULT.delay_type);
    cfg.pickup_level = 16'h0200;
    // Default delay with magnitude parked just above the release point
    step(600 + $urandom_range(100), 0);
    repeat (9) step(497, 0);
    step(496, 0);
    for (int i = 0; i < 3; i++) begin
      cfg.min_delay = 19'(i == 0 ? 0 : i == 1 ? 1 : 3);
      repeat (5) step(700, 0);
      step(0, 0);
    end
    // Blocking at pick-up, blocking after start, forced block in and out of test
    step(700, 1);
    step(700, 0);
    step(0, 0);
    step(700, 0);
    step(700, 1);
    step(0, 0);
    step(700, 0, 1, 0);
    step(700, 0, 1, 1);
    step(0, 0);
    cfg.under_mode = 1;
    step(400, 0);
    step(520, 1);
    step(540, 0);
    cfg.under_mode = 0;
    cfg.time_dial = 12'h002;
    cfg.min_delay = 19'h0_0004;
    for (int k = 0; k < 4; k++) begin
      cfg.delay_type = prot_pkg::delay_type_t'(k[1]);
      cfg.curve_series = prot_pkg::curve_series_t'(k[0]);
      repeat (14) step(300 + $urandom_range(800), $urandom_range(9) == 0);
      step(0, 0);
    end
    // Inverse timing with no trip floor configured
    cfg.min_delay = 19'h0_0000;
    repeat (5) step(1000, 0);
    step(0, 0);
    summarize();
  end
endmodule

// >>> rtl/pickup_compare.sv
// Pick-up comparator with fixed reset hysteresis
module pickup_compare #(
  parameter int MAG_W = prot_pkg::MAG_W
) (
  input wire logic [MAG_W-1:0] magnitude,
  input wire logic [MAG_W-1:0] level,
  input wire logic under_mode,
  input wire logic active,
  output logic next_active
);
  logic [MAG_W+7:0] mag_scaled;
  logic [MAG_W+7:0] lvl_scaled;
  logic [MAG_W+7:0] mag_full;
  logic [MAG_W+7:0] lvl_full;

  always_comb begin
    mag_scaled = (MAG_W+8)'(magnitude) * (MAG_W+8)'(prot_pkg::RESET_PCT);
    lvl_scaled = (MAG_W+8)'(level) * (MAG_W+8)'(prot_pkg::RESET_PCT);
    mag_full = (MAG_W+8)'(magnitude) * (MAG_W+8)'(prot_pkg::FULL_PCT);
    lvl_full = (MAG_W+8)'(level) * (MAG_W+8)'(prot_pkg::FULL_PCT);
    if (!active) begin
      next_active = under_mode ? (magnitude < level) : (magnitude > level); // RULE1
    end else begin
      // Release point sits 3 percent of the level below pick-up (over) or 3 percent of the magnitude above it (under)
      next_active = under_mode ? (mag_scaled <= lvl_full) : (mag_full >= lvl_scaled); // RULE2
    end
  end
endmodule

// >>> rtl/prot_pkg.sv
// Constants and carrier types for the protection pick-up, blocking and trip timer
// Overview of operation
// RULE1: Pick-up asserts when magnitude rises above or falls below the pick-up level.
// RULE2: Pick-up releases at a fixed 97 percent of the pick-up level; under mode releases once 97 percent of magnitude exceeds the level.
// RULE3: Blocking input is sampled at the start of each processing cycle.
// RULE4: Start is asserted only while pick-up is active and blocking is inactive.
// RULE5: Unblocked pick-up asserts start and then runs the operating time characteristic.
// RULE6: Blocking at pick-up asserts blocked and stops start and trip timing.
// RULE7: Blocking after start clears start and releases as if pick-up reset.
// RULE8: Blocking issues a display event and a stamped event with values and type.
// RULE9: Software switch may force blocking only while global test mode is active.
// RULE10: Blocking source must assert blocking 5 ms before the operating delay expires.
// RULE11: Instant mode asserts trip in the same cycle as start.
// RULE12: Definite mode trips after the fixed delay while pick-up stays active.
// RULE13: Inverse mode trips after a delay set by pick-up level versus magnitude.
// RULE14: Delay type code 0 is definite time, code 1 inverse, default definite.
// RULE15: Definite delay is the minimum-delay setting, 5 ms steps, default 40 ms.
// RULE16: Minimum delay of zero in definite mode gives instantaneous operation.
// RULE17: In inverse mode the minimum delay is a floor on trip time.
// RULE18: Configure minimum delay zero when no inverse trip floor is wanted.
// RULE19: Curve series 0 IEC default, 1 IEEE, used only in inverse mode.
// RULE20: All timers advance once per fixed-period processing cycle.
package prot_pkg;
  localparam int CLK_NS = 50;
  localparam int CYCLE_NS = 5_000_000;
  localparam int CYCLE_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_NS = 5_000_000;
  localparam int STEP_CYCLES = STEP_NS / CYCLE_NS;
  localparam int RESET_PCT = 97;
  localparam int FULL_PCT = 100;
  localparam int MIN_DELAY_DEFAULT_NS = 40_000_000;
  localparam int MIN_DELAY_DEFAULT = MIN_DELAY_DEFAULT_NS / STEP_NS;
  localparam int MAG_W = 16;
  localparam int DELAY_W = 19;
  localparam int DIAL_W = 12;
  localparam int STAMP_W = 32;

  typedef enum logic {
    definite_time_mode = 1'b0,
    inverse_time_mode = 1'b1
  } delay_type_t;

  typedef enum logic {
    curve_iec = 1'b0,
    curve_ieee = 1'b1
  } curve_series_t;

  typedef struct packed {
    delay_type_t delay_type;
    curve_series_t curve_series;
    logic under_mode;
    logic [DELAY_W-1:0] min_delay;
    logic [DIAL_W-1:0] time_dial;
    logic [MAG_W-1:0] pickup_level;
  } settings_t;

  typedef struct packed {
    logic display_event;
    logic block_event;
    logic [STAMP_W-1:0] stamp;
    logic [MAG_W-1:0] start_value;
    logic fault_under;
  } block_report_t;

  localparam settings_t SETTINGS_DEFAULT = '{
    delay_type: definite_time_mode,
    curve_series: curve_iec,
    under_mode: 1'b0,
    min_delay: DELAY_W'(MIN_DELAY_DEFAULT),
    time_dial: DIAL_W'(1),
    pickup_level: MAG_W'(1)
  };
endpackage

// >>> rtl/protection_pickup_block_timer.sv
// Protection core: pick-up, blocking, start and trip timing per processing cycle
module protection_pickup_block_timer #(
  parameter int CYCLE_CLKS = prot_pkg::CYCLE_CLKS,
  parameter int MAG_W = prot_pkg::MAG_W,
  parameter int DELAY_W = prot_pkg::DELAY_W,
  parameter int DIAL_W = prot_pkg::DIAL_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [MAG_W-1:0] magnitude,
  input wire prot_pkg::settings_t settings,
  input wire logic block_in,
  input wire logic test_mode,
  input wire logic sw_block,
  output logic pickup,
  output logic start,
  output logic blocked,
  output logic trip,
  output logic cycle_tick,
  output prot_pkg::block_report_t report
);
  localparam int ACC_W = MAG_W + DIAL_W + 8;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_started = 4'b0010,
    st_tripped = 4'b0100,
    st_blocked = 4'b1000
  } state_t;

  state_t state, next_state;
  logic [31:0] div_count, next_div_count;
  logic eval, next_eval;
  logic blk_s, next_blk_s;
  logic [MAG_W-1:0] mag_s, next_mag_s;
  logic next_pickup;
  logic pu_eval;
  logic [DELAY_W-1:0] op_count, next_op_count;
  logic [ACC_W-1:0] acc, next_acc;
  logic [MAG_W-1:0] start_value, next_start_value;
  logic [prot_pkg::STAMP_W-1:0] stamp, next_stamp;
  prot_pkg::block_report_t next_report;
  logic block_eff;
  logic [MAG_W-1:0] excess;
  logic [ACC_W-1:0] weight;
  logic [ACC_W-1:0] inv_limit;
  logic [DELAY_W-1:0] elapsed;
  logic floor_met;
  logic timer_done;
  logic instant;

  // Software forcing only counts during global test mode
  assign block_eff = block_in | (test_mode & sw_block); // RULE9

  pickup_compare #(
    .MAG_W(MAG_W)
  ) u_compare (
    .magnitude(mag_s),
    .level(settings.pickup_level),
    .under_mode(settings.under_mode),
    .active(pickup),
    .next_active(pu_eval)
  );

  // Processing cycle divider: sample on the tick, evaluate one clock later
  always_comb begin
    cycle_tick = (div_count == 32'(CYCLE_CLKS - 1)); // RULE20
    next_div_count = cycle_tick ? 32'h0000_0000 : div_count + 32'h0000_0001;
    next_eval = cycle_tick;
    next_blk_s = cycle_tick ? block_eff : blk_s; // RULE3
    next_mag_s = cycle_tick ? magnitude : mag_s;
    next_stamp = cycle_tick ? stamp + 32'h0000_0001 : stamp;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 32'h0000_0000;
      eval <= 1'b0;
      blk_s <= 1'b0;
      mag_s <= '0;
      stamp <= '0;
    end else begin
      div_count <= next_div_count;
      eval <= next_eval;
      blk_s <= next_blk_s;
      mag_s <= next_mag_s;
      stamp <= next_stamp;
    end
  end

  // Operating characteristic
  always_comb begin
    // Inside the hysteresis band the magnitude is short of the level: zero excess, so no inverse-time progress toward trip
    if (settings.under_mode) begin
      excess = (mag_s < settings.pickup_level) ? settings.pickup_level - mag_s : '0;
    end else begin
      excess = (mag_s > settings.pickup_level) ? mag_s - settings.pickup_level : '0;
    end
    if (settings.curve_series == prot_pkg::curve_ieee) begin // RULE19
      weight = ACC_W'((2 * MAG_W)'(excess) * (2 * MAG_W)'(excess) >> MAG_W) + ACC_W'(excess);
    end else begin
      weight = ACC_W'(excess);
    end
    // Integrated excess reaches dial times level: time falls as the excess grows
    inv_limit = ACC_W'(settings.time_dial) * ACC_W'(settings.pickup_level); // RULE13
    elapsed = op_count + DELAY_W'(prot_pkg::STEP_CYCLES);
    floor_met = (elapsed >= settings.min_delay); // RULE17
    if (settings.delay_type == prot_pkg::inverse_time_mode) begin // RULE14
      timer_done = floor_met && (acc + weight >= inv_limit); // RULE13
    end else begin
      timer_done = floor_met; // RULE12 RULE15
    end
    instant = (settings.delay_type == prot_pkg::definite_time_mode)
      && (settings.min_delay == '0); // RULE11 RULE16
  end

  // State sequencing on each evaluation cycle
  always_comb begin
    next_state = state;
    next_pickup = pickup;
    next_op_count = op_count;
    next_acc = acc;
    next_start_value = start_value;
    next_report = report;
    next_report.display_event = 1'b0;
    next_report.block_event = 1'b0;
    if (eval) begin
      next_pickup = pu_eval;
      unique case (state)
        st_idle: begin
          next_op_count = '0;
          next_acc = '0;
          if (pu_eval && blk_s) begin
            next_state = st_blocked; // RULE6
          end else if (pu_eval) begin
            next_start_value = mag_s;
            next_state = instant ? st_tripped : st_started; // RULE5 RULE11
          end
        end
        st_started: begin
          if (!pu_eval) begin
            next_state = st_idle;
          end else if (blk_s) begin
            next_state = st_blocked; // RULE7
          end else if (timer_done) begin
            next_state = st_tripped; // RULE12
          end else begin
            next_op_count = elapsed; // RULE20
            next_acc = acc + weight;
          end
        end
        st_tripped: begin
          if (!pu_eval) begin
            next_state = st_idle;
          end else if (blk_s) begin
            next_state = st_blocked; // RULE7
          end
        end
        st_blocked: begin
          if (!pu_eval) begin
            next_state = st_idle;
          end
        end
      endcase
      if (next_state == st_blocked && state != st_blocked) begin
        next_report.display_event = 1'b1; // RULE8
        next_report.block_event = 1'b1; // RULE8
        next_report.stamp = stamp;
        next_report.start_value = (state == st_idle) ? mag_s : start_value;
        next_report.fault_under = settings.under_mode;
        next_op_count = '0;
        next_acc = '0;
      end
      if (next_state == st_idle) begin
        next_op_count = '0;
        next_acc = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      pickup <= 1'b0;
      op_count <= '0;
      acc <= '0;
      start_value <= '0;
      report <= '0;
    end else begin
      state <= next_state;
      pickup <= next_pickup;
      op_count <= next_op_count;
      acc <= next_acc;
      start_value <= next_start_value;
      report <= next_report;
    end
  end

  assign start = (state == st_started) || (state == st_tripped); // RULE4
  assign trip = (state == st_tripped);
  assign blocked = (state == st_blocked);

  sequence eval_idle_pickup_s;
    eval && state == st_idle && pu_eval;
  endsequence

  sequence eval_started_blocked_s;
    eval && (state == st_started || state == st_tripped) && pu_eval && blk_s;
  endsequence

  start_not_blocked_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    start |-> !blocked && pickup)
    else $error("start while blocked or without pick-up");

  block_sample_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    cycle_tick |=> blk_s == $past(block_eff) && eval)
    else $error("blocking not sampled on the cycle tick");

  sw_block_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    cycle_tick && !test_mode && !block_in |=> !blk_s)
    else $error("software block honoured outside test mode");

  blocked_entry_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    eval_idle_pickup_s ##0 blk_s |=> blocked && !start && !trip)
    else $error("pick-up under blocking did not give blocked");

  instant_trip_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE11
    eval_idle_pickup_s ##0 (!blk_s && instant) |=> start && trip)
    else $error("instant mode did not trip with start");

  late_block_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    eval_started_blocked_s |=> !start && !trip && blocked)
    else $error("start not cleared by later blocking");

  block_event_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    $rose(blocked) |-> report.display_event && report.block_event ##1
    !report.block_event)
    else $error("blocking events missing or not single pulses");

  trip_floor_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE17
    $rose(trip) && $past(state) == st_started |-> $past(elapsed) >= settings.min_delay)
    else $error("trip before minimum delay");

  dt_trip_time_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE12
    eval && state == st_started && pu_eval && !blk_s && floor_met
    && settings.delay_type == prot_pkg::definite_time_mode |=> trip)
    else $error("definite delay expired without trip");

  hysteresis_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    eval && pickup && !settings.under_mode
    && 32'(mag_s) * 32'(prot_pkg::FULL_PCT) >= 32'(settings.pickup_level)
    * 32'(prot_pkg::RESET_PCT) |=> pickup)
    else $error("pick-up released above reset threshold");

  sequence eval_release_s;
    eval && !pu_eval;
  endsequence

  sequence eval_fresh_start_s;
    eval && state == st_idle && pu_eval && !blk_s;
  endsequence

  pickup_level_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    eval && !pickup && (settings.under_mode ? mag_s < settings.pickup_level
    : mag_s > settings.pickup_level) |=> pickup)
    else $error("pick-up missed beyond the level");

  release_all_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    eval_release_s |=> !pickup && !start && !trip && !blocked)
    else $error("outputs held after pick-up release");

  fresh_start_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    eval_fresh_start_s |=> start && !blocked && start_value == $past(mag_s))
    else $error("unblocked pick-up did not start");

  trip_needs_start_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    trip |-> start)
    else $error("trip without start");

  late_block_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    eval_started_blocked_s |=> op_count == '0 && acc == '0)
    else $error("timers not released by later blocking");

  event_source_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    report.block_event |-> $rose(blocked) && report.display_event)
    else $error("blocking event without fresh blocking");

  stamp_count_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE20
    cycle_tick |=> stamp == $past(stamp) + 32'h0000_0001)
    else $error("time stamp not advanced on the cycle tick");

  sw_block_force_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    cycle_tick && test_mode && sw_block |=> blk_s)
    else $error("software block ignored in test mode");

  eval_after_tick_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    eval |-> $past(cycle_tick))
    else $error("evaluation without a preceding sample");

  quiet_between_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE20
    !eval |=> $stable(state) && $stable(pickup))
    else $error("outputs moved between evaluations");

  floor_wait_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE17
    eval && state == st_started && !floor_met |=> !trip)
    else $error("trip before the minimum delay elapsed");
endmodule
